// ### rtl/ccdrs_phase_gen.sv
/*
  Clock-phase generator: steps the four image phases in either vertical
  direction and the three register phases in order.
  Assumes image step requests come from the sequencer as one-cycle pulses; register steps are held high for one step per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module ccdrs_phase_gen
  import ccdrs_pkg::*;
(
  input  wire logic core_clk,  // Core clock
  input  wire logic rst,       // Synchronous reset, active high
  ccdrs_phase_if.gen ph        // Phase requests and masks
);

  logic [1:0] vidx_reg;
  logic [2:0] hidx_reg;

  // Image phase index: 0,1,2,3 toward W/X or 0,3,2,1 toward Y/Z
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vidx_reg <= 2'h0;
    end else if (ph.vstep) begin
      vidx_reg <= ph.vdir_yz ? vidx_reg - 2'h1 : vidx_reg + 2'h1;  // [RULE1] [RULE2]
    end
  end

  // Register step index 0..5 cyclic
  always_ff @(posedge core_clk) begin
    if (rst || !ph.hrun) begin
      hidx_reg <= 3'h0;
    end else if (ph.hstep) begin
      hidx_reg <= (hidx_reg == 3'(HPHASE_STEPS - 1)) ? 3'h0 : hidx_reg + 3'h1;  // [RULE3] [RULE4]
    end
  end

  // Two adjacent image phases high: leading phase and the one after it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ph.img_phase <= IMG_INTEGRATE;
    end else begin
      ph.img_phase <= (4'h1 << vidx_reg) |
                      (4'h1 << (ph.vdir_yz ? vidx_reg - 2'h1 : vidx_reg + 2'h1));
    end
  end

  // Register phase mask, each phase high three of six steps
  always_ff @(posedge core_clk) begin
    if (rst || !ph.hrun) begin
      ph.hphase <= HCLK_REST;
    end else begin
      ph.hphase <= HCLK_SEQ[hidx_reg];  // [RULE13]
    end
  end

  assign ph.vwrap = (vidx_reg == 2'h0);
  assign ph.hwrap = (hidx_reg == 3'(HPHASE_STEPS - 1));  // Last step of a pixel

endmodule : ccdrs_phase_gen
`default_nettype wire

// ### rtl/ccdrs_phase_if.sv
/*
  Interface carrying the phase-step requests and the phase masks between
  the sequencer and its clock-phase generator.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface ccdrs_phase_if;
  logic       vstep;      // Advance image phases one step
  logic       vdir_yz;    // Direction toward the Y/Z register pair
  logic       hstep;      // Advance register phases one step
  logic       hrun;       // Horizontal transport active
  logic [3:0] img_phase;  // Image phase mask
  logic [2:0] hphase;     // Register phase mask
  logic       vwrap;      // Image phase back at phase one
  logic       hwrap;      // Register phases at a pixel's last step

  modport seq (output vstep, vdir_yz, hstep, hrun, input img_phase, hphase, vwrap, hwrap);
  modport gen (input vstep, vdir_yz, hstep, hrun, output img_phase, hphase, vwrap, hwrap);
endinterface : ccdrs_phase_if
`default_nettype wire

// ### rtl/ccdrs_pkg.sv
/*
  Package for the full-frame sensor readout sequencer: frame geometry,
  timing figures and the sequencer state type.
  Assumes a 25 MHz core clock; every slower rate is derived from it.
*/
package ccdrs_pkg;

  // Core clock and transport rates
  localparam int unsigned CORE_CLK_HZ     = 25_000_000;
  localparam int unsigned HCLK_RATE_HZ    = 25_000_000;
  localparam int unsigned VCLK_RATE_HZ    = 50_000;

  // Horizontal: one pixel is six core-clock steps at 3/6 duty
  localparam int unsigned HPHASE_STEPS    = 6;
  localparam int unsigned HSTEP_CYCLES    = (CORE_CLK_HZ / HCLK_RATE_HZ) / HPHASE_STEPS > 0 ?
                                            (CORE_CLK_HZ / HCLK_RATE_HZ) / HPHASE_STEPS : 1;

  // Vertical: one line shift is four phase steps at the vertical rate
  localparam int unsigned VPHASE_STEPS    = 4;
  localparam int unsigned VSTEP_CYCLES    = CORE_CLK_HZ / (VCLK_RATE_HZ * VPHASE_STEPS);

  // Charge reset least time, microseconds, and its cycle count (truncating division)
  localparam int unsigned CR_MIN_US       = 10;
  localparam int unsigned CR_MIN_CYCLES   = (CR_MIN_US * (CORE_CLK_HZ / 1_000_000));
  localparam int unsigned LINE_CYCLES     = CORE_CLK_HZ / VCLK_RATE_HZ;
  localparam int unsigned CR_CYCLES       = LINE_CYCLES > CR_MIN_CYCLES ? LINE_CYCLES
                                                                        : CR_MIN_CYCLES;

  // Frame geometry, dummy and reference elements included
  localparam int unsigned FRAME_LINES     = 4728;
  localparam int unsigned REG_CELLS       = 7013;

  // Counter widths
  localparam int unsigned CNT_W           = 16;

  // Phase masks: bit0..bit3 = image phase one..four high
  localparam logic [3:0]  IMG_INTEGRATE   = 4'h3;
  localparam logic [3:0]  IMG_REST        = 4'h0;
  // Horizontal mask: bit0..bit2 = phase one..three high
  localparam logic [2:0]  HCLK_REST       = 3'h0;
  // Register masks per step: each phase high three of six steps
  localparam logic [HPHASE_STEPS-1:0][2:0] HCLK_SEQ = {3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};

  typedef enum logic [2:0] {
    CCDRS_IDLE,
    CCDRS_RESET,
    CCDRS_INTEG,
    CCDRS_VSHIFT,
    CCDRS_HREAD
  } ccdrs_state_t;

endpackage : ccdrs_pkg

// ### rtl/ccdrs_sequencer.sv
/*
  Camera-side timing generator for a full-frame sensor: charge reset after
  the trigger edge, integration while the trigger is high, vertical line
  shifts and horizontal readout of every line, then idle.
  Assumes the trigger and mode inputs are synchronous to core_clk.
*/
// Summary of operation
// [RULE1] Toward the W/X registers the image phases step one, two, three, four, repeating.
// [RULE2] Toward the Y/Z registers the image phases step one, four, three, two, repeating.
// [RULE3] The top register clocks step phase one, two, three cyclically.
// [RULE4] The bottom register clocks step phase one, two, three cyclically.
// [RULE5] The charge reset pulse is given in the first line period after the trigger rises.
// [RULE6] Charge integrates while the trigger is high and readout waits until it falls.
// [RULE7] After a frame's readout the sequencer idles until the next trigger.
// [RULE8] Odd lines leave through X and even lines through W, marked by a line parity flag.
// [RULE9] In dual output mode top and bottom register clocks are driven identically.
// [RULE10] Horizontal transport runs at 25 MHz and vertical transport at 50 kHz; the code moves one pixel per six 25 MHz register phase steps.
// [RULE11] Clocks and gates of an unused register section are held low.
// [RULE12] The image transfer gate follows image phase one, or is held low to sub-sample.
// [RULE13] Register clocks run at 3/6 duty and never faster than 25 MHz.
// [RULE14] The charge reset lasts at least 10 us, one line time, with image clocks low.
// [RULE15] Line and pixel counts cover the whole frame, dummy and reference elements included.
`timescale 1ns/1ps
`default_nettype none
module ccdrs_sequencer
  import ccdrs_pkg::*;
#(
  parameter int unsigned LINES_PER_FRAME = FRAME_LINES,  // Lines shifted per frame
  parameter int unsigned CELLS_PER_LINE  = REG_CELLS,    // Register cells read per line
  parameter int unsigned STEP_CYCLES     = VSTEP_CYCLES, // Core cycles per image step
  parameter int unsigned RESET_CYCLES    = CR_CYCLES     // Core cycles of charge reset
)(
  input  wire logic       core_clk,               // 25 MHz core clock
  input  wire logic       rst,                    // Synchronous reset, active high
  input  wire logic       exposure_trigger,       // Exposure trigger, high integrates
  input  wire logic       readout_to_yz,          // 1: shift toward Y/Z, 0: toward W/X
  input  wire logic       dual_output,            // 1: top and bottom both read
  input  wire logic       use_top,                // Single mode: 1 top, 0 bottom register
  input  wire logic       subsample,              // Hold transfer gate low on line shift
  output logic            image_phase_one,        // Image clock phase one
  output logic            image_phase_two,        // Image clock phase two
  output logic            image_phase_three,      // Image clock phase three
  output logic            image_phase_four,       // Image clock phase four
  output logic            image_transfer_gate,    // Image transfer gate
  output logic            register_split_gate,    // Gate between register pair
  output logic            top_hclk_phase_one,     // Top register clock phase one
  output logic            top_hclk_phase_two,     // Top register clock phase two
  output logic            top_hclk_phase_three,   // Top register clock phase three
  output logic            bottom_hclk_phase_one,  // Bottom register clock phase one
  output logic            bottom_hclk_phase_two,  // Bottom register clock phase two
  output logic            bottom_hclk_phase_three,// Bottom register clock phase three
  output logic            top_summing_gate,       // Top summing gate enable
  output logic            bottom_summing_gate,    // Bottom summing gate enable
  output logic            top_output_gate,        // Top output gate enable
  output logic            bottom_output_gate,     // Bottom output gate enable
  output logic            reset_gate,             // Output node reset pulse
  output logic            charge_reset_pulse,     // Charge reset on substrate
  output logic            pixel_valid,            // One pixel ready at the outputs
  output logic            line_odd,               // Line parity: 1 odd via X, 0 even via W
  output logic            frame_busy              // Frame sequence in progress
);

  ccdrs_state_t           state_reg;
  ccdrs_state_t           state_next;
  logic                   trig_d_reg;
  logic [CNT_W-1:0]       tick_reg;
  logic [CNT_W-1:0]       line_reg;
  logic [CNT_W-1:0]       cell_reg;
  logic [2:0]             vsteps_reg;
  logic                   trig_rise;
  logic                   tick_done;
  logic                   hpix_done;
  logic                   top_on;
  logic                   bot_on;

  ccdrs_phase_if ph ();

  ccdrs_phase_gen u_phase_gen (
    .core_clk (core_clk),
    .rst      (rst),
    .ph       (ph.gen)
  );

  // Register sections in use
  function automatic logic section_on(input logic dual, input logic top_sel,
                                      input logic is_top);
    section_on = dual | (top_sel == is_top);
  endfunction : section_on

  assign top_on    = section_on(dual_output, use_top, 1'b1);
  assign bot_on    = section_on(dual_output, use_top, 1'b0);
  assign trig_rise = exposure_trigger & ~trig_d_reg;
  assign tick_done = (tick_reg == CNT_W'(STEP_CYCLES - 1));
  assign hpix_done = (cell_reg == CNT_W'(CELLS_PER_LINE - 1)) && ph.hwrap && ph.hstep;

  // Trigger edge history
  always_ff @(posedge core_clk) begin
    if (rst) begin
      trig_d_reg <= 1'b0;
    end else begin
      trig_d_reg <= exposure_trigger;
    end
  end

  // State transitions
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CCDRS_IDLE:   if (trig_rise) state_next = CCDRS_RESET;               // [RULE7]
      CCDRS_RESET:  if (tick_reg == CNT_W'(RESET_CYCLES - 1)) begin
                      state_next = CCDRS_INTEG;                            // [RULE14]
                    end
      CCDRS_INTEG:  if (!exposure_trigger) state_next = CCDRS_VSHIFT;      // [RULE6]
      CCDRS_VSHIFT: if (tick_done && vsteps_reg == 3'(VPHASE_STEPS - 1)) begin
                      state_next = CCDRS_HREAD;
                    end
      CCDRS_HREAD:  if (hpix_done) begin
                      state_next = (line_reg == CNT_W'(LINES_PER_FRAME - 1)) ?
                                   CCDRS_IDLE : CCDRS_VSHIFT;              // [RULE15]
                    end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= CCDRS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Step timer for reset and vertical steps (50 kHz line rate)
  always_ff @(posedge core_clk) begin
    if (rst || state_next != state_reg) begin
      tick_reg <= '0;
    end else if (state_reg == CCDRS_RESET) begin
      tick_reg <= tick_reg + CNT_W'(1);
    end else if (state_reg == CCDRS_VSHIFT) begin
      tick_reg <= tick_done ? '0 : tick_reg + CNT_W'(1);  // [RULE10]
    end
  end

  // Vertical step count within one line shift
  always_ff @(posedge core_clk) begin
    if (rst || state_reg != CCDRS_VSHIFT) begin
      vsteps_reg <= 3'h0;
    end else if (tick_done) begin
      vsteps_reg <= vsteps_reg + 3'h1;
    end
  end

  // Line counter over the whole frame
  always_ff @(posedge core_clk) begin
    if (rst || state_reg == CCDRS_IDLE) begin
      line_reg <= '0;
    end else if (state_reg == CCDRS_HREAD && hpix_done) begin
      line_reg <= line_reg + CNT_W'(1);  // [RULE15]
    end
  end

  // Cell counter per line
  always_ff @(posedge core_clk) begin
    if (rst || state_reg != CCDRS_HREAD) begin
      cell_reg <= '0;
    end else if (ph.hstep && ph.hwrap) begin
      cell_reg <= hpix_done ? '0 : cell_reg + CNT_W'(1);
    end
  end

  // Phase generator requests
  assign ph.vstep   = (state_reg == CCDRS_VSHIFT) && tick_done;   // [RULE1] [RULE2]
  assign ph.vdir_yz = readout_to_yz;
  assign ph.hrun    = (state_reg == CCDRS_HREAD);
  assign ph.hstep   = ph.hrun;  // One step per core cycle, 25 MHz steps [RULE10] [RULE13]

  // Image clocks, transfer gates and charge reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      {image_phase_four, image_phase_three, image_phase_two, image_phase_one} <= IMG_INTEGRATE;
      image_transfer_gate <= 1'b0;
      register_split_gate <= 1'b0;
      charge_reset_pulse  <= 1'b0;
    end else begin
      charge_reset_pulse  <= (state_next == CCDRS_RESET);                           // [RULE5]
      {image_phase_four, image_phase_three, image_phase_two, image_phase_one} <=
        (state_next == CCDRS_RESET) ? IMG_REST : ph.img_phase;                      // [RULE14]
      image_transfer_gate <= (state_next == CCDRS_VSHIFT) && !subsample &&
                             ph.img_phase[0];                                       // [RULE12]
      register_split_gate <= (state_next == CCDRS_VSHIFT);
    end
  end

  // Register clocks, gated per section; unused sections held low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      {top_hclk_phase_three, top_hclk_phase_two, top_hclk_phase_one}          <= HCLK_REST;
      {bottom_hclk_phase_three, bottom_hclk_phase_two, bottom_hclk_phase_one} <= HCLK_REST;
      top_summing_gate    <= 1'b0;
      bottom_summing_gate <= 1'b0;
      top_output_gate     <= 1'b0;
      bottom_output_gate  <= 1'b0;
      reset_gate          <= 1'b0;
    end else begin
      {top_hclk_phase_three, top_hclk_phase_two, top_hclk_phase_one} <=
        top_on ? ph.hphase : HCLK_REST;                                   // [RULE3] [RULE9] [RULE11]
      {bottom_hclk_phase_three, bottom_hclk_phase_two, bottom_hclk_phase_one} <=
        bot_on ? ph.hphase : HCLK_REST;                                   // [RULE4] [RULE9] [RULE11]
      top_summing_gate    <= top_on & ph.hphase[2];                       // [RULE11]
      bottom_summing_gate <= bot_on & ph.hphase[2];                       // [RULE11]
      top_output_gate     <= top_on;
      bottom_output_gate  <= bot_on;
      reset_gate          <= ph.hrun & ph.hphase[0];
    end
  end

  // Pixel strobe and line parity for re-interleaving the two streams
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pixel_valid <= 1'b0;
      line_odd    <= 1'b0;
      frame_busy  <= 1'b0;
    end else begin
      pixel_valid <= ph.hrun && ph.hwrap;
      line_odd    <= ~line_reg[0];  // Line 1 is line_reg 0 [RULE8]
      frame_busy  <= (state_next != CCDRS_IDLE) || ph.hrun ||
                     (ph.hphase != HCLK_REST);  // Until register clocks rest
    end
  end

endmodule : ccdrs_sequencer
`default_nettype wire

// ### testbench/ccd_frame_readout_sequencer_tb.sv
/* Self-checking bench: sequencer plus sensor stand-in, short frames.
   One 25 MHz clock, sync reset held five cycles. */
`timescale 1ns/1ps
`default_nettype none
module ccd_frame_readout_sequencer_tb;
  localparam int unsigned NL = 3; // Lines per frame
  localparam int unsigned NC = 4; // Cells per line
  localparam int unsigned NR = 3; // Charge reset cycles
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  logic              trig = 1'b0;
  logic              yz = 1'b0;
  logic              dual = 1'b1;
  logic              top = 1'b1;
  logic              sub = 1'b0;
  logic [3:0]        img;
  logic [2:0]        tp;
  logic [2:0]        bt;
  logic              itg, split, crp, pv, odd, busy;
  logic [10:0][15:0] cnt;
  int                errors = 0;
  int                num_checks = 0;
  // Clock
  always #20 core_clk = ~core_clk;
  ccdrs_sequencer #(.LINES_PER_FRAME(NL), .CELLS_PER_LINE(NC), .STEP_CYCLES(2),
    .RESET_CYCLES(NR)) dut (.core_clk, .rst, .exposure_trigger(trig), .readout_to_yz(yz),
    .dual_output(dual), .use_top(top), .subsample(sub), .image_phase_one(img[0]),
    .image_phase_two(img[1]), .image_phase_three(img[2]), .image_phase_four(img[3]),
    .image_transfer_gate(itg), .register_split_gate(split), .top_hclk_phase_one(tp[0]),
    .top_hclk_phase_two(tp[1]), .top_hclk_phase_three(tp[2]), .bottom_hclk_phase_one(bt[0]),
    .bottom_hclk_phase_two(bt[1]), .bottom_hclk_phase_three(bt[2]), .top_summing_gate(),
    .bottom_summing_gate(), .top_output_gate(), .bottom_output_gate(), .reset_gate(),
    .charge_reset_pulse(crp), .pixel_valid(pv), .line_odd(odd), .frame_busy(busy));
  ccdrs_sensor_model sensor (.core_clk, .rst, .img, .itg, .tp, .bt, .crp, .trig, .pv, .odd,
    .cnt);
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask : cmp
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // One frame: trigger held for hold cycles, optional stray trigger in readout
  task automatic run_frame(input logic [3:0] mode, input int hold, input bit poke,
                           output int early, output logic [10:0][15:0] base);
    int n;
    early = 0;
    n = 0;
    @(posedge core_clk);
    {yz, dual, top, sub} <= mode;
    // Direction change settles in the image mask before tallies are taken
    repeat (4) @(negedge core_clk);
    base = cnt;
    @(posedge core_clk);
    trig <= 1'b1;
    repeat (hold) begin
      @(negedge core_clk);
      if (split !== 1'b0 || tp !== 3'h0 || bt !== 3'h0) early++;
    end
    @(posedge core_clk);
    trig <= 1'b0;
    if (poke) begin
      while (bt === 3'h0 && n < 500) begin
        @(negedge core_clk);
        n++;
      end
      @(posedge core_clk);
      trig <= 1'b1;
      repeat (2) @(posedge core_clk);
      trig <= 1'b0;
    end
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (busy !== 1'b0 && n < 3000);
    cmp(16'(n < 3000), 16'h1, "frame end");
  endtask : run_frame
  task automatic cmp_frame(input logic [10:0][15:0] b, input logic [15:0] f, r, t, bo,
                           input logic [15:0] g);
    cmp(cnt[0] - b[0], f, "W/X steps");
    cmp(cnt[1] - b[1], r, "Y/Z steps");
    cmp(cnt[2] - b[2], 16'h0, "bad steps");
    cmp(cnt[3] - b[3], 16'(NL), "lines");
    cmp(cnt[4] - b[4], 16'(NC), "even pixels W");
    cmp(cnt[5] - b[5], 16'(2 * NC), "odd pixels X");
    cmp(cnt[6] - b[6], t, "top clock cycles");
    cmp(cnt[7] - b[7], bo, "bottom clock cycles");
    cmp(cnt[8] - b[8], 16'(NR), "dark reset cycles");
    cmp(16'(cnt[9] != b[9]), g, "transfer gate");
  endtask : cmp_frame
  task automatic test_idle;
    @(negedge core_clk);
    cmp(16'(img), 16'h3, "integrate mask");
    cmp(16'({crp, busy, tp, bt}), 16'h0, "rest outputs");
    $display("test_idle done");
  endtask : test_idle
  task automatic test_wx_dual;
    logic [10:0][15:0] b;
    int                e;
    run_frame(4'b0110, 8, 1'b0, e, b);
    cmp_frame(b, 16'(4 * NL), 16'h0, 16'(6 * NC * NL), 16'(6 * NC * NL), 16'h1);
    $display("test_wx_dual done");
  endtask : test_wx_dual
  task automatic test_yz_top_sub;
    logic [10:0][15:0] b;
    int                e;
    run_frame(4'b1011, 8, 1'b0, e, b);
    cmp_frame(b, 16'h0, 16'(4 * NL), 16'(6 * NC * NL), 16'h0, 16'h0);
    $display("test_yz_top_sub done");
  endtask : test_yz_top_sub
  task automatic test_bottom_poke;
    logic [10:0][15:0] b;
    int                e;
    run_frame(4'b0000, 8, 1'b1, e, b);
    cmp_frame(b, 16'(4 * NL), 16'h0, 16'h0, 16'(6 * NC * NL), 16'h1);
    repeat (20) @(negedge core_clk);
    cmp(16'(busy), 16'h0, "stays idle");
    $display("test_bottom_poke done");
  endtask : test_bottom_poke
  task automatic test_long_hold;
    logic [10:0][15:0] b;
    int                e;
    run_frame(4'b0110, 40, 1'b0, e, b);
    cmp(16'(e), 16'h0, "readout during exposure");
    cmp(16'(cnt[10] - b[10] >= 16'd34 && cnt[10] - b[10] <= 16'd37), 16'h1, "integ");
    $display("test_long_hold done");
  endtask : test_long_hold
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    test_idle();
    test_wx_dual();
    test_yz_top_sub();
    test_bottom_poke();
    test_long_hold();
    test_done();
  end
  // Watchdog
  initial begin
    #400000;
    errors++;
    $display("ERROR %0t: watchdog expired", $time);
    test_done();
  end
endmodule : ccd_frame_readout_sequencer_tb
`default_nettype wire

// ### testbench/ccdrs_sensor_model.sv
/* Sensor stand-in: tallies charge motion, pixels and gate activity.
   Watches the sequencer's pins on the core clock. */
`timescale 1ns/1ps
`default_nettype none
module ccdrs_sensor_model (
  input  wire logic              core_clk, // Clock
  input  wire logic              rst,      // Reset
  input  wire logic [3:0]        img,      // Image phases
  input  wire logic              itg,      // Transfer gate
  input  wire logic [2:0]        tp,       // Top phases
  input  wire logic [2:0]        bt,       // Bottom phases
  input  wire logic              crp,      // Charge reset
  input  wire logic              trig,     // Trigger
  input  wire logic              pv,       // Pixel strobe
  input  wire logic              odd,      // Line parity
  output logic      [10:0][15:0] cnt       // Tallies
);
  logic [3:0] img_q;
  // Tally charge steps, pixels and gates
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt   <= '0;
      img_q <= 4'h3;
    end else begin
      img_q <= img;
      if (img != img_q && img != 4'h0 && img_q != 4'h0) begin
        if (img == {img_q[2:0], img_q[3]}) cnt[0] <= cnt[0] + 16'h1;
        else if (img == {img_q[0], img_q[3:1]}) cnt[1] <= cnt[1] + 16'h1;
        else cnt[2] <= cnt[2] + 16'h1;
        if (img == 4'h3) cnt[3] <= cnt[3] + 16'h1; // Line lands in register
      end
      if (pv && !odd) cnt[4] <= cnt[4] + 16'h1;
      if (pv && odd) cnt[5] <= cnt[5] + 16'h1;
      if (tp != 3'h0) cnt[6] <= cnt[6] + 16'h1;
      if (bt != 3'h0) cnt[7] <= cnt[7] + 16'h1;
      if (crp && img == 4'h0) cnt[8] <= cnt[8] + 16'h1;
      if (itg) cnt[9] <= cnt[9] + 16'h1;
      if (trig && img == 4'h3) cnt[10] <= cnt[10] + 16'h1;
    end
  end
endmodule : ccdrs_sensor_model
`default_nettype wire

// ### testbench/ccdrs_seq_props.sv
/* Concurrent checks on the sequencer's pins.
   Bound into ccdrs_sequencer; one clock domain, sync reset. */
`timescale 1ns/1ps
`default_nettype none
module ccdrs_seq_props #(
  parameter int unsigned RESET_CYCLES = 3  // Charge reset length
)(
  input wire logic core_clk,                // Clock
  input wire logic rst,                     // Reset
  input wire logic exposure_trigger,        // Trigger
  input wire logic readout_to_yz,           // Direction
  input wire logic dual_output,             // Dual mode
  input wire logic use_top,                 // Single section
  input wire logic subsample,               // Sub-sample
  input wire logic image_phase_one,         // Image one
  input wire logic image_phase_two,         // Image two
  input wire logic image_phase_three,       // Image three
  input wire logic image_phase_four,        // Image four
  input wire logic image_transfer_gate,     // Transfer gate
  input wire logic register_split_gate,     // Split gate
  input wire logic top_hclk_phase_one,      // Top one
  input wire logic top_hclk_phase_two,      // Top two
  input wire logic top_hclk_phase_three,    // Top three
  input wire logic bottom_hclk_phase_one,   // Bottom one
  input wire logic bottom_hclk_phase_two,   // Bottom two
  input wire logic bottom_hclk_phase_three, // Bottom three
  input wire logic charge_reset_pulse,      // Charge reset
  input wire logic top_summing_gate,        // Top summing gate
  input wire logic bottom_summing_gate,     // Bottom summing gate
  input wire logic top_output_gate,         // Top output gate
  input wire logic bottom_output_gate,      // Bottom output gate
  input wire logic pixel_valid,             // Pixel strobe
  input wire logic frame_busy               // Busy
);
  logic [3:0]  img;
  logic [3:0]  img_q;
  logic [2:0]  top;
  logic [2:0]  bot;
  logic        step;
  logic [15:0] cr_len_reg;
  // Gathered phase masks and a step marker
  assign img  = {image_phase_four, image_phase_three, image_phase_two, image_phase_one};
  assign top  = {top_hclk_phase_three, top_hclk_phase_two, top_hclk_phase_one};
  assign bot  = {bottom_hclk_phase_three, bottom_hclk_phase_two, bottom_hclk_phase_one};
  assign step = img != img_q && img != 4'h0 && img_q != 4'h0;
  // Previous image mask
  always_ff @(posedge core_clk) img_q <= img;
  // Length of the running charge reset
  always_ff @(posedge core_clk) begin
    cr_len_reg <= (rst || !charge_reset_pulse) ? 16'h0 : cr_len_reg + 16'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_wx_order: assert property (
    step && !readout_to_yz |-> img == {img_q[2:0], img_q[3]})
    else $error("image phases left W/X order");
  chk_yz_order: assert property (
    step && readout_to_yz |-> img == {img_q[0], img_q[3:1]})
    else $error("image phases left Y/Z order");
  chk_top_rotate: assert property (
    top == 3'h1 |=> top == 3'h3 ##1 top == 3'h2 ##1 top == 3'h6 ##1 top == 3'h4
      ##1 top == 3'h5)
    else $error("top clocks out of order");
  chk_bot_rotate: assert property (
    bot == 3'h1 |=> bot == 3'h3 ##1 bot == 3'h2 ##1 bot == 3'h6 ##1 bot == 3'h4
      ##1 bot == 3'h5)
    else $error("bottom clocks out of order");
  chk_cr_after_edge: assert property (
    $rose(exposure_trigger) && !frame_busy |=> charge_reset_pulse)
    else $error("no charge reset after trigger edge");
  chk_cr_length: assert property (
    $fell(charge_reset_pulse) |-> cr_len_reg == RESET_CYCLES)
    else $error("charge reset length wrong");
  chk_cr_dark: assert property (
    charge_reset_pulse |-> img == 4'h0)
    else $error("image clocks high during charge reset");
  chk_wait_trigger: assert property (
    $rose(register_split_gate) |-> !$past(exposure_trigger))
    else $error("line shift while trigger high");
  chk_idle_hold: assert property (
    !frame_busy && !$rose(exposure_trigger) |=> !frame_busy && top == 3'h0 && bot == 3'h0)
    else $error("left idle without trigger");
  chk_dual_same: assert property (
    $past(dual_output) && dual_output |-> top == bot)
    else $error("top and bottom clocks differ");
  chk_unused_quiet: assert property (
    !dual_output && $stable(dual_output) && $stable(use_top) |-> (use_top ? bot : top) == 3'h0)
    else $error("unused section toggles");
  chk_gates_quiet: assert property (
    !dual_output && $stable(dual_output) && $stable(use_top) |->
      (use_top ? {bottom_summing_gate, bottom_output_gate}
               : {top_summing_gate, top_output_gate}) == 2'h0)
    else $error("unused section gates active");
  chk_gate_follow: assert property (
    register_split_gate && $stable(subsample)
      |-> image_transfer_gate == (image_phase_one && !subsample))
    else $error("transfer gate wrong");
  chk_pixel_spacing: assert property (
    pixel_valid |=> !pixel_valid ##1 !pixel_valid)
    else $error("pixels closer than three cycles");
endmodule : ccdrs_seq_props
bind ccdrs_sequencer ccdrs_seq_props #(.RESET_CYCLES(RESET_CYCLES)) u_props (
  .core_clk, .rst, .exposure_trigger, .readout_to_yz, .dual_output, .use_top, .subsample,
  .image_phase_one, .image_phase_two, .image_phase_three, .image_phase_four,
  .image_transfer_gate, .register_split_gate, .top_hclk_phase_one, .top_hclk_phase_two,
  .top_hclk_phase_three, .bottom_hclk_phase_one, .bottom_hclk_phase_two,
  .bottom_hclk_phase_three, .charge_reset_pulse, .top_summing_gate, .bottom_summing_gate,
  .top_output_gate, .bottom_output_gate, .pixel_valid, .frame_busy);
`default_nettype wire
